// ---- design/asat_pkg.sv ----
package asat_pkg;

  // ****************************************************************
  // command codes of the register port (word registers)
  // ****************************************************************
  localparam logic [7:0] CMD_CHG_EN = 8'h06;    // charging channel enables
  localparam logic [7:0] CMD_BK_EN = 8'h07;     // backup channel enables
  localparam logic [7:0] CMD_CHG_IVL = 8'h08;   // charge_scan_interval
  localparam logic [7:0] CMD_BK_IVL = 8'h09;    // backup_scan_interval
  localparam logic [7:0] CMD_AUX_LO = 8'h0A;    // aux_input_low_threshold
  localparam logic [7:0] CMD_AUX_HI = 8'h0B;    // aux_input_high_threshold
  localparam logic [7:0] CMD_VIN_LO = 8'h0C;    // supply_in_low_threshold
  localparam logic [7:0] CMD_VIN_HI = 8'h0D;    // supply_in_high_threshold
  localparam logic [7:0] CMD_STK_LO = 8'h0E;    // stack_low_threshold
  localparam logic [7:0] CMD_STK_HI = 8'h0F;    // stack_high_threshold
  localparam logic [7:0] CMD_OUT_LO = 8'h10;    // out_rail_low_threshold
  localparam logic [7:0] CMD_OUT_HI = 8'h11;    // out_rail_high_threshold
  localparam logic [7:0] CMD_TMP_LO = 8'h12;    // temp_cold_threshold
  localparam logic [7:0] CMD_TMP_HI = 8'h13;    // temp_hot_threshold
  localparam logic [7:0] CMD_ICHG_LO = 8'h14;   // charge_current_low_threshold
  localparam logic [7:0] CMD_IIN_HI = 8'h15;    // input_current_high_threshold
  localparam logic [7:0] CMD_CELL_LO = 8'h16;   // cell_low_threshold
  localparam logic [7:0] CMD_ALARM = 8'h23;     // alarm flags
  localparam logic [7:0] CMD_ALARM_EN = 8'h24;  // alarm enables
  localparam logic [7:0] CMD_STATUS = 8'h25;    // monitor status

  // ****************************************************************
  // configuration array: one word per code from CMD_CHG_IVL upward
  // ****************************************************************
  localparam int CFG_WORDS = 15;
  localparam int IX_CHG_IVL = 0;
  localparam int IX_BK_IVL = 1;
  localparam int IX_AUX_LO = 2;
  localparam int IX_AUX_HI = 3;
  localparam int IX_VIN_LO = 4;
  localparam int IX_VIN_HI = 5;
  localparam int IX_STK_LO = 6;
  localparam int IX_STK_HI = 7;
  localparam int IX_OUT_LO = 8;
  localparam int IX_OUT_HI = 9;
  localparam int IX_TMP_LO = 10;
  localparam int IX_TMP_HI = 11;
  localparam int IX_ICHG_LO = 12;
  localparam int IX_IIN_HI = 13;
  localparam int IX_CELL_LO = 14;

  // ****************************************************************
  // reset values and field layouts
  // ****************************************************************
  localparam logic [15:0] IVL_RST = 16'h0064;     // 100 ticks
  localparam logic [15:0] CHG_EN_RST = 16'h0FFE;  // all charging channels
  localparam logic [15:0] BK_EN_RST = 16'h0000;   // no backup channels
  localparam logic [15:0] CH_EN_MASK = 16'h0FFE;  // writable bits [11:1]
  localparam logic [15:0] ALARM_MASK = 16'h1FFF;  // implemented alarm bits
  localparam int CELL4_EN_BIT = 11;               // backup_cell4_measure_enable

  // channel numbers, equal to their enable bit positions
  localparam logic [3:0] CH_ICHG = 4'h1;
  localparam logic [3:0] CH_TEMP = 4'h2;
  localparam logic [3:0] CH_AUX = 4'h3;
  localparam logic [3:0] CH_IIN = 4'h4;
  localparam logic [3:0] CH_OUT = 4'h5;
  localparam logic [3:0] CH_STK = 4'h6;
  localparam logic [3:0] CH_VIN = 4'h7;
  localparam logic [3:0] CH_CELL1 = 4'h8;
  localparam logic [3:0] CH_LAST = 4'hB;

  // alarm flag positions
  localparam int A_CELL_LO = 0;
  localparam int A_AUX_LO = 1;
  localparam int A_AUX_HI = 2;
  localparam int A_VIN_LO = 3;
  localparam int A_VIN_HI = 4;
  localparam int A_STK_LO = 5;
  localparam int A_STK_HI = 6;
  localparam int A_OUT_LO = 7;
  localparam int A_OUT_HI = 8;
  localparam int A_TMP_LO = 9;
  localparam int A_TMP_HI = 10;
  localparam int A_ICHG_LO = 11;
  localparam int A_IIN_HI = 12;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 5000;       // 200 MHz
  localparam int SCAN_TICK_US = 400;         // interval weight
  localparam int SCAN_TICK_CYC = SCAN_TICK_US * 1000000 / CLK_PERIOD_PS;

  // scan sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_PICK = 3'h1,
    ST_CONV = 3'h2,
    ST_WAIT = 3'h4
  } asat_st_t;

endpackage

// ---- design/asat_monitor.sv ----
// Contract
// - backup bit 11 adds cell four to group
// - charging wait is interval times 400us
// - measure enabled channels, wait, repeat forever
// - backup mode uses its own wait interval
// - shunt or test may skip charging wait
// - aux below low threshold raises alarm
// - aux above high threshold raises alarm
// - supply below low threshold raises alarm
// - supply above high threshold raises alarm
// - stack below low threshold raises alarm
// - stack above high threshold raises alarm
// - output rail below low threshold raises alarm
// - output rail above high threshold raises alarm
// - die temperature below cold threshold alarms
// - die temperature above hot threshold alarms
// - charge current below threshold raises alarm
// - input current above threshold raises alarm
// - any cell below threshold raises alarm
// - alarm flags cleared by writing zero only
`timescale 1ns/1ps
`default_nettype none

module asat_monitor
  import asat_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = SCAN_TICK_CYC  // cycles per 400us
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  input wire logic BACKUP_MODE,
  input wire logic SCAN_OVERRIDE,
  output logic ADC_REQ,
  output logic [3:0] ADC_CH,
  input wire logic ADC_DONE,
  input wire logic [15:0] ADC_DATA,
  input wire logic SMBALERT_IN,
  output logic SMBALERT_O,
  output logic SMBALERT_OE
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    asat_st_t st;                          // sequencer state
    logic [3:0] ch;                        // channel being looked at
    logic [16:0] tick;                     // 400us prescaler
    logic [15:0] ivl;                      // ticks left in the wait
    logic [CFG_WORDS-1:0][15:0] cfg;       // intervals and thresholds
    logic [15:0] chg_en;                   // charging channel enables
    logic [15:0] bk_en;                    // backup channel enables
    logic [15:0] alarm;                    // sticky alarm flags
    logic [15:0] alarm_en;                 // alarm enables
    logic [15:0] rdata;                    // read answer
    logic req;                             // conversion request pulse
    logic alert;                           // alert pin pulled low
    logic [1:0] pin_sync;                  // alert pin synchroniser
  } asat_state_t;

  asat_state_t q_q;   // registered state
  asat_state_t q_d;   // next state

  logic [15:0] ch_en;   // enables of the current mode
  logic [12:0] ev;      // alarm events of this cycle
  logic got;            // a measurement completes now
  logic [16:0] tick_last;  // prescaler end value
  logic [15:0] status;  // monitor status word

  assign tick_last = 17'(TICK_CYCLES - 1);

  // ****************************************************************
  // alarm event detection
  // ****************************************************************
  // events only form when a conversion of the scanned channel finishes
  always_comb begin
    got = (q_q.st == ST_CONV) && ADC_DONE;
    ev = '0;
    if (got) begin
      // channel decode, each event gated by its own enable
      if (q_q.ch == CH_AUX) begin
        ev[A_AUX_LO] = ADC_DATA < q_q.cfg[IX_AUX_LO];
        ev[A_AUX_HI] = ADC_DATA > q_q.cfg[IX_AUX_HI];
      end else if (q_q.ch == CH_VIN) begin
        ev[A_VIN_LO] = ADC_DATA < q_q.cfg[IX_VIN_LO];
        ev[A_VIN_HI] = ADC_DATA > q_q.cfg[IX_VIN_HI];
      end else if (q_q.ch == CH_STK) begin
        ev[A_STK_LO] = ADC_DATA < q_q.cfg[IX_STK_LO];
        ev[A_STK_HI] = ADC_DATA > q_q.cfg[IX_STK_HI];
      end else if (q_q.ch == CH_OUT) begin
        ev[A_OUT_LO] = ADC_DATA < q_q.cfg[IX_OUT_LO];
        ev[A_OUT_HI] = ADC_DATA > q_q.cfg[IX_OUT_HI];
      end else if (q_q.ch == CH_TEMP) begin
        ev[A_TMP_LO] = ADC_DATA < q_q.cfg[IX_TMP_LO];
        ev[A_TMP_HI] = ADC_DATA > q_q.cfg[IX_TMP_HI];
      end else if (q_q.ch == CH_ICHG) begin
        ev[A_ICHG_LO] = ADC_DATA < q_q.cfg[IX_ICHG_LO];
      end else if (q_q.ch == CH_IIN) begin
        ev[A_IIN_HI] = ADC_DATA > q_q.cfg[IX_IIN_HI];
      end else if (q_q.ch >= CH_CELL1) begin
        // every cell shares one threshold and one flag
        ev[A_CELL_LO] = ADC_DATA < q_q.cfg[IX_CELL_LO];
      end
    end
    ev = ev & q_q.alarm_en[12:0];
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    q_d = q_q;
    q_d.req = 1'b0;
    // backup group reads its own enables, cell four at bit 11
    ch_en = BACKUP_MODE ? q_q.bk_en : q_q.chg_en;
    status = {13'h0000, q_q.pin_sync[1], q_q.st == ST_WAIT, BACKUP_MODE};

    // alert pin level through two flip-flops
    q_d.pin_sync = {q_q.pin_sync[0], SMBALERT_IN};

    // sequencer
    case (q_q.st)
      ST_PICK: begin
        if (q_q.ch > CH_LAST) begin
          // group done: load the interval of the current mode
          q_d.tick = '0;
          q_d.ch = CH_ICHG;
          if (BACKUP_MODE) begin
            q_d.ivl = q_q.cfg[IX_BK_IVL];
          end else begin
            q_d.ivl = q_q.cfg[IX_CHG_IVL];
          end
          // zero interval, or override in charging mode, restarts at once
          if (q_d.ivl != 16'h0000 &&
              (BACKUP_MODE || !SCAN_OVERRIDE)) begin
            q_d.st = ST_WAIT;
          end
        end else if (ch_en[q_q.ch]) begin
          // enabled channel: ask the converter once
          q_d.req = 1'b1;
          q_d.st = ST_CONV;
        end else begin
          // disabled channel: skip
          q_d.ch = q_q.ch + 4'h1;
        end
      end
      ST_CONV: begin
        // hold until the result arrives
        if (ADC_DONE) begin
          q_d.ch = q_q.ch + 4'h1;
          q_d.st = ST_PICK;
        end
      end
      ST_WAIT: begin
        if (!BACKUP_MODE && SCAN_OVERRIDE) begin
          // shunting or test takes over the schedule
          q_d.st = ST_PICK;
        end else if (q_q.tick == tick_last) begin
          q_d.tick = '0;
          q_d.ivl = q_q.ivl - 16'h0001;
          if (q_q.ivl == 16'h0001) begin
            q_d.st = ST_PICK;
          end
        end else begin
          q_d.tick = q_q.tick + 17'h00001;
        end
      end
      default: begin
        // unreachable code: recover to a fresh group
        q_d.st = ST_PICK;
        q_d.ch = CH_ICHG;
      end
    endcase

    // register writes
    if (REG_WR) begin
      if (REG_ADDR == CMD_CHG_EN) begin
        q_d.chg_en = REG_WDATA & CH_EN_MASK;
      end else if (REG_ADDR == CMD_BK_EN) begin
        q_d.bk_en = REG_WDATA & CH_EN_MASK;
      end else if (REG_ADDR >= CMD_CHG_IVL && REG_ADDR <= CMD_CELL_LO) begin
        q_d.cfg[REG_ADDR - CMD_CHG_IVL] = REG_WDATA;
      end else if (REG_ADDR == CMD_ALARM_EN) begin
        q_d.alarm_en = REG_WDATA & ALARM_MASK;
      end
    end

    // alarm flags: zero bits clear, ones keep, events win
    if (REG_WR && REG_ADDR == CMD_ALARM) begin
      q_d.alarm = q_q.alarm & REG_WDATA;
    end
    q_d.alarm = q_d.alarm | {3'b000, ev};

    // alert pulled low while any flag stands
    q_d.alert = |q_d.alarm;

    // register reads, answered on the next edge
    if (REG_RD) begin
      if (REG_ADDR == CMD_CHG_EN) begin
        q_d.rdata = q_q.chg_en;
      end else if (REG_ADDR == CMD_BK_EN) begin
        q_d.rdata = q_q.bk_en;
      end else if (REG_ADDR >= CMD_CHG_IVL && REG_ADDR <= CMD_CELL_LO) begin
        q_d.rdata = q_q.cfg[REG_ADDR - CMD_CHG_IVL];
      end else if (REG_ADDR == CMD_ALARM) begin
        q_d.rdata = q_q.alarm;
      end else if (REG_ADDR == CMD_ALARM_EN) begin
        q_d.rdata = q_q.alarm_en;
      end else if (REG_ADDR == CMD_STATUS) begin
        q_d.rdata = status;
      end else begin
        // unmapped code reads zero
        q_d.rdata = 16'h0000;
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      q_q <= '0;
      q_q.st <= ST_PICK;
      q_q.ch <= CH_ICHG;
      q_q.cfg[IX_CHG_IVL] <= IVL_RST;
      q_q.cfg[IX_BK_IVL] <= IVL_RST;
      q_q.chg_en <= CHG_EN_RST;
      q_q.bk_en <= BK_EN_RST;
    end else begin
      q_q <= q_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign REG_RDATA = q_q.rdata;
  assign ADC_REQ = q_q.req;
  assign ADC_CH = q_q.ch;
  assign SMBALERT_O = 1'b0;
  assign SMBALERT_OE = q_q.alert;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  // end of one group seen in the pick state
  sequence s_group_end;
    q_q.st == ST_PICK && q_q.ch > CH_LAST;
  endsequence

  // last tick of the last interval unit
  sequence s_wait_done;
    q_q.st == ST_WAIT && q_q.tick == tick_last && q_q.ivl == 16'h0001 &&
      !(!BACKUP_MODE && SCAN_OVERRIDE);
  endsequence

  chk_cell4_skip: assert property (
    q_q.st == ST_PICK && BACKUP_MODE && q_q.ch == 4'hB &&
      !q_q.bk_en[CELL4_EN_BIT] |=> !ADC_REQ && ADC_CH == 4'hC)
    else $error("cell four measured with its backup enable clear");

  chk_charge_wait: assert property (
    s_group_end ##0 (!BACKUP_MODE && !SCAN_OVERRIDE &&
      q_q.cfg[IX_CHG_IVL] != 16'h0000) |=>
      q_q.st == ST_WAIT && q_q.ivl == $past(q_q.cfg[IX_CHG_IVL]))
    else $error("charging wait not loaded from its interval");

  chk_group_repeat: assert property (
    s_wait_done |=> q_q.st == ST_PICK && q_q.ch == 4'h1)
    else $error("group did not restart after its wait");

  chk_backup_wait: assert property (
    s_group_end ##0 (BACKUP_MODE && q_q.cfg[IX_BK_IVL] != 16'h0000) |=>
      q_q.st == ST_WAIT && q_q.ivl == $past(q_q.cfg[IX_BK_IVL]))
    else $error("backup wait not loaded from its interval");

  chk_override_skip: assert property (
    q_q.st == ST_WAIT && !BACKUP_MODE && SCAN_OVERRIDE |=>
      q_q.st == ST_PICK)
    else $error("override did not end the charging wait");

  chk_req_once: assert property (
    ADC_REQ |=> !ADC_REQ [*2])
    else $error("conversion requested twice in a row");

  chk_aux_low: assert property (
    got && q_q.ch == CH_AUX && q_q.alarm_en[A_AUX_LO] &&
      ADC_DATA < q_q.cfg[IX_AUX_LO] |=> q_q.alarm[A_AUX_LO] && SMBALERT_OE)
    else $error("aux low alarm or alert missing");

  chk_stack_high: assert property (
    got && q_q.ch == CH_STK && q_q.alarm_en[A_STK_HI] &&
      ADC_DATA > q_q.cfg[IX_STK_HI] |=> q_q.alarm[A_STK_HI])
    else $error("stack high alarm missing");

  chk_aux_high: assert property (
    got && q_q.ch == CH_AUX && q_q.alarm_en[A_AUX_HI] &&
      ADC_DATA > q_q.cfg[IX_AUX_HI] |=> q_q.alarm[A_AUX_HI])
    else $error("aux high alarm missing");

  chk_supply_low: assert property (
    got && q_q.ch == CH_VIN && q_q.alarm_en[A_VIN_LO] &&
      ADC_DATA < q_q.cfg[IX_VIN_LO] |=> q_q.alarm[A_VIN_LO])
    else $error("supply low alarm missing");

  chk_supply_high: assert property (
    got && q_q.ch == CH_VIN && q_q.alarm_en[A_VIN_HI] &&
      ADC_DATA > q_q.cfg[IX_VIN_HI] |=> q_q.alarm[A_VIN_HI])
    else $error("supply high alarm missing");

  chk_stack_low: assert property (
    got && q_q.ch == CH_STK && q_q.alarm_en[A_STK_LO] &&
      ADC_DATA < q_q.cfg[IX_STK_LO] |=> q_q.alarm[A_STK_LO])
    else $error("stack low alarm missing");

  chk_rail_low: assert property (
    got && q_q.ch == CH_OUT && q_q.alarm_en[A_OUT_LO] &&
      ADC_DATA < q_q.cfg[IX_OUT_LO] |=> q_q.alarm[A_OUT_LO])
    else $error("output rail low alarm missing");

  chk_rail_high: assert property (
    got && q_q.ch == CH_OUT && q_q.alarm_en[A_OUT_HI] &&
      ADC_DATA > q_q.cfg[IX_OUT_HI] |=> q_q.alarm[A_OUT_HI])
    else $error("output rail high alarm missing");

  chk_temp_cold: assert property (
    got && q_q.ch == CH_TEMP && q_q.alarm_en[A_TMP_LO] &&
      ADC_DATA < q_q.cfg[IX_TMP_LO] |=> q_q.alarm[A_TMP_LO])
    else $error("cold alarm missing");

  chk_temp_hot: assert property (
    got && q_q.ch == CH_TEMP && q_q.alarm_en[A_TMP_HI] &&
      ADC_DATA > q_q.cfg[IX_TMP_HI] |=> q_q.alarm[A_TMP_HI])
    else $error("hot alarm missing");

  chk_charge_low: assert property (
    got && q_q.ch == CH_ICHG && q_q.alarm_en[A_ICHG_LO] &&
      ADC_DATA < q_q.cfg[IX_ICHG_LO] |=> q_q.alarm[A_ICHG_LO])
    else $error("charge current low alarm missing");

  chk_input_high: assert property (
    got && q_q.ch == CH_IIN && q_q.alarm_en[A_IIN_HI] &&
      ADC_DATA > q_q.cfg[IX_IIN_HI] |=> q_q.alarm[A_IIN_HI])
    else $error("input current high alarm missing");

  chk_cell_low: assert property (
    got && q_q.ch >= CH_CELL1 && q_q.alarm_en[A_CELL_LO] &&
      ADC_DATA < q_q.cfg[IX_CELL_LO] |=> q_q.alarm[A_CELL_LO])
    else $error("cell low alarm missing");

  chk_flag_clear: assert property (
    REG_WR && REG_ADDR == CMD_ALARM && ev == 13'h0000 |=>
      q_q.alarm == ($past(q_q.alarm) & $past(REG_WDATA)))
    else $error("alarm write did not clear only zero bits");

  chk_no_event: assert property (
    !got |=> (q_q.alarm & ~$past(q_q.alarm)) == 16'h0000)
    else $error("alarm set without a finished measurement");

  chk_alert_level: assert property (
    ##1 SMBALERT_OE == (q_q.alarm != 16'h0000))
    else $error("alert pin disagrees with the alarm flags");

endmodule

`default_nettype wire

// ---- sim/asat_adc_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// converter stand-in: answers every request after LAT cycles
// ****************************************************************
module asat_adc_model (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic ADC_REQ,
  input wire logic [3:0] ADC_CH,
  input wire logic [7:0] LAT,
  output logic ADC_DONE,
  output logic [15:0] ADC_DATA
);
  logic [15:0] val [0:15];  // result per channel, set by the bench
  logic busy;  // a conversion is outstanding
  logic [7:0] cnt;  // cycles left in this conversion
  logic [3:0] ch;  // channel under conversion

  // result stands one cycle; otherwise the data bus churns
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      ch <= 4'h0;
      ADC_DONE <= 1'b0;
      ADC_DATA <= 16'hA5A5;
    end else begin
      ADC_DONE <= 1'b0;
      ADC_DATA <= ~ADC_DATA;  // no stale result outside the done cycle
      if (ADC_REQ) begin
        busy <= 1'b1;
        cnt <= LAT;
        ch <= ADC_CH;
      end else if (busy && cnt > 8'h01) begin
        cnt <= cnt - 8'h01;
      end else if (busy) begin
        busy <= 1'b0;
        ADC_DONE <= 1'b1;
        ADC_DATA <= val[ch];
      end
    end
  end
endmodule

`default_nettype wire

// ---- sim/adc_scan_alarm_thresholds_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module adc_scan_alarm_thresholds_tb;
  import asat_pkg::*;
  // ****************************************************************
  // bench settings and signals
  // ****************************************************************
  localparam int TICK = 4;  // shortened interval tick in cycles
  localparam int DLY = 1;  // drive delay after the edge
  localparam int CEIL = 30000;  // cycle ceiling of the run
  localparam logic [12:0] HI = 13'h1554;  // alarms that fire above
  localparam logic [3:0] ACH [0:12] = '{4'hA, 4'h3, 4'h3, 4'h7, 4'h7,
    4'h6, 4'h6, 4'h5, 4'h5, 4'h2, 4'h2, 4'h1, 4'h4};  // channel per alarm
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic REG_WR = 1'b0;
  logic [15:0] REG_WDATA = 16'h0000;
  logic REG_RD = 1'b0;
  logic BACKUP_MODE = 1'b0;
  logic SCAN_OVERRIDE = 1'b0;
  logic [15:0] REG_RDATA, ADC_DATA;
  logic [3:0] ADC_CH;
  logic ADC_REQ, ADC_DONE, SMBALERT_O, SMBALERT_OE;
  logic [7:0] lat = 8'h05;  // converter latency
  wire logic alert_pin;  // open-drain alert wire with pull-up
  int cyc = 0;
  int fail_count = 0;
  int checked = 0;

  assign alert_pin = SMBALERT_OE ? SMBALERT_O : 1'b1;
  always #2.5 MCLK = ~MCLK;

  // cycle count and hang guard
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      fail_count++;
      $display("CHECK FAILED t=%0t run too long", $time);
      tally_and_finish();
    end
  end

  asat_monitor #(.TICK_CYCLES(TICK)) i_asat_monitor (.MCLK(MCLK),
    .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .BACKUP_MODE(BACKUP_MODE), .SCAN_OVERRIDE(SCAN_OVERRIDE),
    .ADC_REQ(ADC_REQ), .ADC_CH(ADC_CH), .ADC_DONE(ADC_DONE),
    .ADC_DATA(ADC_DATA), .SMBALERT_IN(alert_pin),
    .SMBALERT_O(SMBALERT_O), .SMBALERT_OE(SMBALERT_OE));
  asat_adc_model i_asat_adc_model (.MCLK(MCLK), .RST_N(RST_N),
    .ADC_REQ(ADC_REQ), .ADC_CH(ADC_CH), .LAT(lat), .ADC_DONE(ADC_DONE),
    .ADC_DATA(ADC_DATA));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic tick();
    @(posedge MCLK);
    #DLY;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    tick();
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    tick();
    REG_WR = 1'b0;
  endtask

  // read answer lands on the edge that takes the strobe
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp,
                       input string what);
    tick();
    REG_ADDR = a;
    REG_RD = 1'b1;
    tick();
    REG_RD = 1'b0;
    chk(REG_RDATA, exp, what);
  endtask

  // wait for a request (req high) or a result on channel c
  task automatic wait_ev(input logic req, input logic [3:0] c);
    int n = 0;
    do begin
      tick();
      n++;
    end while (!((req ? ADC_REQ : ADC_DONE) === 1'b1 && ADC_CH === c)
               && n < 3000);
    chk(16'(n < 3000), 16'h0001, "converter event");
  endtask

  task automatic next_ch(output logic [3:0] c);
    int n = 0;
    do begin
      tick();
      n++;
    end while (ADC_REQ !== 1'b1 && n < 3000);
    c = ADC_CH;
  endtask

  // cycles from the last result of a group to the next group start
  task automatic gap(input logic [3:0] last, input logic [3:0] first,
                     output int g);
    int t0;
    wait_ev(1'b1, first);
    wait_ev(1'b0, last);
    t0 = cyc;
    wait_ev(1'b1, first);
    g = cyc - t0;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs();
    logic [15:0] v;
    chk(REG_RDATA, 16'h0000, "read data after reset");
    rdchk(CMD_CHG_IVL, 16'h0064, "charge interval reset");
    rdchk(CMD_BK_IVL, 16'h0064, "backup interval reset");
    rdchk(CMD_BK_EN, 16'h0000, "backup enable reset");
    rdchk(CMD_CHG_EN, 16'h0FFE, "charge enable reset");
    for (int i = 2; i < 15; i++) begin
      rdchk(8'h08 + 8'(i), 16'h0000, "threshold reset");
    end
    wr(8'h3F, 16'hBEEF);
    rdchk(8'h3F, 16'h0000, "unmapped read");
    for (int i = 0; i < 15; i++) begin
      v = (i < 2) ? 16'h0002 : 16'h5A00 + 16'(i);
      wr(8'h08 + 8'(i), v);
      rdchk(8'h08 + 8'(i), v, "readback");
    end
    wr(CMD_BK_EN, 16'hFFFF);
    rdchk(CMD_BK_EN, 16'h0FFE, "backup enable bits");
    wr(CMD_ALARM_EN, 16'hFFFF);
    rdchk(CMD_ALARM_EN, 16'h1FFF, "alarm enable bits");
    wr(CMD_ALARM_EN, 16'h0000);
    $display("t_regs done");
  endtask

  task automatic t_order();
    logic [3:0] c;
    lat = 8'h01;
    wait_ev(1'b1, 4'h1);
    for (int k = 2; k <= 12; k++) begin
      next_ch(c);
      chk({12'h000, c}, (k == 12) ? 16'h0001 : 16'(k), "scan order");
    end
    lat = 8'h05;
    $display("t_order done");
  endtask

  task automatic t_interval();
    int a, b;
    logic [3:0] c;
    wr(CMD_CHG_IVL, 16'h0002);
    gap(4'hB, 4'h1, a);
    wr(CMD_CHG_IVL, 16'h0007);
    gap(4'hB, 4'h1, b);
    chk(16'(b - a), 16'(5 * TICK), "charging wait step");
    chk(16'(a >= 2 * TICK), 16'h0001, "charging wait length");
    wr(CMD_CHG_IVL, 16'h0032);
    wr(CMD_BK_EN, 16'h0808);
    wr(CMD_BK_IVL, 16'h0003);
    BACKUP_MODE = 1'b1;
    gap(4'hB, 4'h3, a);
    wr(CMD_BK_IVL, 16'h0008);
    gap(4'hB, 4'h3, b);
    chk(16'(b - a), 16'(5 * TICK), "backup wait step");
    wr(CMD_BK_EN, 16'h0008);
    wait_ev(1'b1, 4'h3);
    for (int k = 0; k < 3; k++) begin
      next_ch(c);
      chk({12'h000, c}, 16'h0003, "cell four left out");
    end
    BACKUP_MODE = 1'b0;
    wr(CMD_CHG_IVL, 16'h0064);
    SCAN_OVERRIDE = 1'b1;
    gap(4'hB, 4'h1, a);
    chk(16'(a < 20), 16'h0001, "override skips wait");
    SCAN_OVERRIDE = 1'b0;
    $display("t_interval done");
  endtask

  task automatic t_alarms();
    logic [15:0] m;
    logic [15:0] bad;
    wr(CMD_CHG_IVL, 16'h0001);
    for (int i = 0; i < 13; i++) begin
      m = 16'h0001 << i;
      bad = HI[i] ? 16'h8001 : 16'h7FFF;
      wr((i == 0) ? CMD_CELL_LO : 8'h09 + 8'(i), 16'h8000);
      wr(CMD_ALARM_EN, m);
      wr(CMD_ALARM, 16'h0000);
      wait_ev(1'b1, 4'h1);
      wait_ev(1'b1, 4'h1);
      rdchk(CMD_ALARM, 16'h0000, "equal value quiet");
      i_asat_adc_model.val[ACH[i]] = bad;
      wait_ev(1'b1, 4'h1);
      wait_ev(1'b1, 4'h1);
      rdchk(CMD_ALARM, m, "alarm raised");
      chk({15'h0, SMBALERT_OE}, 16'h0001, "alert low");
      chk({15'h0, alert_pin}, 16'h0000, "alert pin low");
      i_asat_adc_model.val[ACH[i]] = 16'h8000;
      wr(CMD_ALARM_EN, 16'h0000);
      wr(CMD_ALARM, 16'hFFFF);
      rdchk(CMD_ALARM, m, "write one keeps flag");
      wr(CMD_ALARM, ~m);
      rdchk(CMD_ALARM, 16'h0000, "write zero clears");
      i_asat_adc_model.val[ACH[i]] = bad;
      wait_ev(1'b1, 4'h1);
      wait_ev(1'b1, 4'h1);
      rdchk(CMD_ALARM, 16'h0000, "disabled alarm quiet");
      chk({15'h0, SMBALERT_OE}, 16'h0000, "alert released");
      i_asat_adc_model.val[ACH[i]] = 16'h8000;
    end
    $display("t_alarms done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    for (int c = 0; c < 16; c++) begin
      i_asat_adc_model.val[c] = 16'h8000;
    end
    repeat (12) @(posedge MCLK);
    #DLY;
    RST_N = 1'b1;
    t_regs();
    t_order();
    t_interval();
    t_alarms();
    tally_and_finish();
  end
endmodule

`default_nettype wire
